// File: rtl/dmsr_alu.sv
`timescale 1ns/1ps

module dmsr_alu
(
    dmsr_alu_if.alu al
);
    logic sub;
    logic ci;
    logic [7:0] bb;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] low7;

    // **********
    // shared adder
    // **********
    // subtraction adds the complement, so carry out means no borrow
    always_comb
    begin
        sub = (al.op == dmsr_pkg::OP_SUB) || (al.op == dmsr_pkg::OP_SBC);
        bb = sub ? ~al.b : al.b;
        ci = (al.op == dmsr_pkg::OP_ADD) ? 1'b0 :
             (al.op == dmsr_pkg::OP_SUB) ? 1'b1 : al.cin;
        sum = {1'b0, al.a} + {1'b0, bb} + {8'h00, ci};
        nib = {1'b0, al.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        low7 = {1'b0, al.a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
    end

    // **********
    // result and flag select
    // **********
    always_comb
    begin
        al.result = al.b;
        al.c = sum[8];
        al.ac = nib[4];
        al.ov = low7[7] ^ sum[8];
        al.upd_c = 1'b0;
        al.upd_ac = 1'b0;
        al.upd_z = 1'b0;
        al.upd_ov = 1'b0;
        case (al.op)
            dmsr_pkg::OP_ADD, dmsr_pkg::OP_ADC, dmsr_pkg::OP_SUB, dmsr_pkg::OP_SBC:
            begin
                al.result = sum[7:0];
                al.upd_c = 1'b1; // RULE14
                al.upd_ac = 1'b1; // RULE15
                al.upd_z = 1'b1; // RULE16
                al.upd_ov = 1'b1; // RULE17
            end
            dmsr_pkg::OP_AND:
            begin
                al.result = al.a & al.b;
                al.upd_z = 1'b1; // RULE16
            end
            dmsr_pkg::OP_OR:
            begin
                al.result = al.a | al.b;
                al.upd_z = 1'b1; // RULE16
            end
            dmsr_pkg::OP_XOR:
            begin
                al.result = al.a ^ al.b;
                al.upd_z = 1'b1; // RULE16
            end
            dmsr_pkg::OP_INC:
            begin
                al.result = al.b + 8'h01;
                al.upd_z = 1'b1; // RULE16
            end
            dmsr_pkg::OP_DEC:
            begin
                al.result = al.b - 8'h01;
                al.upd_z = 1'b1; // RULE16
            end
            dmsr_pkg::OP_RLC:
            begin
                al.result = {al.b[6:0], al.cin};
                al.c = al.b[7];
                al.upd_c = 1'b1; // RULE14
            end
            dmsr_pkg::OP_RRC:
            begin
                al.result = {al.cin, al.b[7:1]};
                al.c = al.b[0];
                al.upd_c = 1'b1; // RULE14
            end
            default:
            begin
                al.result = al.b;
            end
        endcase
        al.z = (al.result == 8'h00);
    end
endmodule

// File: rtl/dmsr_alu_if.sv
`timescale 1ns/1ps

interface dmsr_alu_if;
    dmsr_pkg::dmsr_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    logic [7:0] result;
    logic c;
    logic ac;
    logic z;
    logic ov;
    logic upd_c;
    logic upd_ac;
    logic upd_z;
    logic upd_ov;

    modport core
    (
        output op, a, b, cin,
        input result, c, ac, z, ov, upd_c, upd_ac, upd_z, upd_ov
    );

    modport alu
    (
        input op, a, b, cin,
        output result, c, ac, z, ov, upd_c, upd_ac, upd_z, upd_ov
    );
endinterface

// File: rtl/dmsr_pkg.sv
package dmsr_pkg;

    // **********
    // data memory map
    // **********
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_INDIRECT_PORT = 8'h00;
    localparam logic [7:0] ADDR_INDIRECT_PTR = 8'h01;
    localparam logic [7:0] ADDR_ACC = 8'h05;
    localparam logic [7:0] ADDR_PCL = 8'h06;
    localparam logic [7:0] ADDR_TBL_PTR = 8'h07;
    localparam logic [7:0] ADDR_TBL_HIGH = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0A;
    localparam logic [7:0] SPECIAL_LAST = 8'h1F;
    localparam logic [7:0] GPR_BASE = 8'h20;
    localparam logic [7:0] GPR_LAST = 8'h3F;
    localparam int GPR_WORDS = 32;
    localparam int GPR_IDX_W = 5;

    // **********
    // reset values and fixed read answers
    // **********
    localparam logic [7:0] UNUSED_READ = 8'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // **********
    // flag register bit positions
    // **********
    localparam int FLAG_C = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_PDF = 4;
    localparam int FLAG_TO = 5;
    localparam logic [7:0] FLAG_WR_MASK = 8'h0F;

    // **********
    // core commands
    // **********
    typedef enum logic [3:0] {
        OP_NOP = 4'b0000,
        OP_ADD = 4'b0001,
        OP_ADC = 4'b0010,
        OP_SUB = 4'b0011,
        OP_SBC = 4'b0100,
        OP_AND = 4'b0101,
        OP_OR = 4'b0110,
        OP_XOR = 4'b0111,
        OP_MOV = 4'b1000,
        OP_INC = 4'b1001,
        OP_DEC = 4'b1010,
        OP_RLC = 4'b1011,
        OP_RRC = 4'b1100,
        OP_STORE = 4'b1101,
        OP_SETB = 4'b1110,
        OP_CLRB = 4'b1111
    } dmsr_op_t;

endpackage

// File: rtl/dmsr_top.sv
`timescale 1ns/1ps

// Summary of operation
// RULE1 - addresses 00H to 1FH decode as fixed special registers
// RULE2 - 32 bytes of read/write general RAM sit at 20H to 3FH
// RULE3 - reading an unused special location gives 00H
// RULE4 - accesses to the indirect port act on the location the pointer holds
// RULE5 - indirect port itself stores nothing: reads 00H, writes do nothing
// RULE6 - indirect pointer is a real register, readable, writable, incrementable
// RULE7 - ALU results land in the accumulator; register moves go through it (with cmd_to_mem set, the code writes the result to memory instead)
// RULE8 - writing the low PC byte jumps within the page, adding a dummy cycle
// RULE9 - table pointer addresses table reads; each read loads the high latch
// RULE10 - flag register is 8 bits; bits 7 and 6 read zero
// RULE11 - program writes leave watchdog-expired and power-down flags alone
// RULE12 - watchdog-expired clears at reset, watchdog clear, stop; sets on timeout
// RULE13 - power-down clears at reset or watchdog clear; sets on stop
// RULE14 - carry: add carry out, subtract no borrow, rotates through carry
// RULE15 - half-carry: low nibble carry on add, no nibble borrow on subtract
// RULE16 - zero flag set when an arithmetic or logic result is zero
// RULE17 - overflow set when carry into bit 7 differs from carry out
// RULE18 - flags are never saved automatically on interrupt or call
// RULE19 - single bits of general RAM can be set or cleared alone
module dmsr_top #(
    parameter int GPR_WORDS = dmsr_pkg::GPR_WORDS
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // command from the instruction decoder
    input wire logic cmd_valid,
    input wire dmsr_pkg::dmsr_op_t cmd_op,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_imm,
    input wire logic cmd_use_imm,
    input wire logic cmd_to_mem,
    input wire logic [2:0] cmd_bit,
    output logic cmd_ready,
    output logic [7:0] rd_data,
    // program counter
    input wire logic [7:0] pc_low_in,
    output logic pc_jump,
    output logic [7:0] pc_jump_low,
    // table read
    input wire logic tbl_read,
    input wire logic [7:0] tbl_high_in,
    output logic [7:0] tbl_ptr,
    output logic [7:0] table_high_latch,
    // system events
    input wire logic wdt_timeout,
    input wire logic watchdog_clear_instruction,
    input wire logic stop_instruction,
    // state seen by the core
    output logic [7:0] acc,
    output logic [7:0] flags
);
    logic [7:0] gpr_mem [GPR_WORDS];
    logic [7:0] indirect_pointer_r;
    logic [7:0] acc_r;
    logic [7:0] tbl_ptr_r;
    logic [7:0] tbl_high_r;
    logic [7:0] rd_data_r;
    logic pc_jump_r;
    logic [7:0] pc_jump_low_r;
    logic carry_r;
    logic nibble_half_flag_r;
    logic zero_r;
    logic twos_complement_flag_r;
    logic power_down_flag_r;
    logic watchdog_expired_flag_r;
    logic [7:0] flags_nxt;
    logic go;
    logic [7:0] eff_addr;
    logic eff_ok;
    logic eff_gpr;
    logic [7:0] mem_val;
    logic [7:0] wr_data;
    logic wr_en;
    logic is_alu;
    logic acc_load;
    logic [7:0] bit_mask;

    dmsr_alu_if alu_bus ();

    dmsr_alu u_alu
    (
        .al(alu_bus.alu)
    );

    // **********
    // command accept
    // **********
    // commands offered during the jump's dummy cycle are dropped
    assign cmd_ready = !pc_jump_r; // RULE8
    assign go = cmd_valid && cmd_ready;

    // **********
    // address resolution
    // **********
    always_comb
    begin
        eff_addr = cmd_addr;
        if (cmd_addr == dmsr_pkg::ADDR_INDIRECT_PORT)
        begin
            eff_addr = indirect_pointer_r; // RULE4
        end
        // a pointer aimed back at the port, or off the map, reaches nothing
        eff_ok = (eff_addr != dmsr_pkg::ADDR_INDIRECT_PORT)
                 && (eff_addr <= dmsr_pkg::GPR_LAST); // RULE5
        eff_gpr = eff_ok && (eff_addr >= dmsr_pkg::GPR_BASE); // RULE2
    end

    // **********
    // read decode
    // **********
    always_comb
    begin
        mem_val = dmsr_pkg::UNUSED_READ; // RULE3 RULE5
        if (eff_gpr)
        begin
            mem_val = gpr_mem[eff_addr[dmsr_pkg::GPR_IDX_W-1:0]]; // RULE2
        end
        else if (eff_ok)
        begin
            case (eff_addr) // RULE1
                dmsr_pkg::ADDR_INDIRECT_PTR: mem_val = indirect_pointer_r; // RULE6
                dmsr_pkg::ADDR_ACC: mem_val = acc_r;
                dmsr_pkg::ADDR_PCL: mem_val = pc_low_in;
                dmsr_pkg::ADDR_TBL_PTR: mem_val = tbl_ptr_r;
                dmsr_pkg::ADDR_TBL_HIGH: mem_val = tbl_high_r;
                dmsr_pkg::ADDR_FLAGS: mem_val = flags;
                default: mem_val = dmsr_pkg::UNUSED_READ; // RULE3
            endcase
        end
    end

    // **********
    // alu hookup
    // **********
    // operand a is always the accumulator: no register-to-register path
    assign alu_bus.op = cmd_op;
    assign alu_bus.a = acc_r; // RULE7
    assign alu_bus.b = cmd_use_imm ? cmd_imm : mem_val;
    assign alu_bus.cin = carry_r;

    // **********
    // write data select
    // **********
    always_comb
    begin
        is_alu = (cmd_op != dmsr_pkg::OP_NOP) && (cmd_op != dmsr_pkg::OP_STORE)
                 && (cmd_op != dmsr_pkg::OP_SETB) && (cmd_op != dmsr_pkg::OP_CLRB);
        bit_mask = 8'h01 << cmd_bit;
        wr_data = alu_bus.result;
        wr_en = 1'b0;
        acc_load = 1'b0;
        case (cmd_op)
            dmsr_pkg::OP_NOP:
            begin
                wr_en = 1'b0;
            end
            dmsr_pkg::OP_STORE:
            begin
                wr_data = acc_r; // RULE7
                wr_en = go;
            end
            dmsr_pkg::OP_SETB:
            begin
                wr_data = mem_val | bit_mask; // RULE19
                wr_en = go;
            end
            dmsr_pkg::OP_CLRB:
            begin
                wr_data = mem_val & ~bit_mask; // RULE19
                wr_en = go;
            end
            default:
            begin
                wr_en = go && cmd_to_mem;
                acc_load = go && !cmd_to_mem; // RULE7
            end
        endcase
    end

    // **********
    // general purpose ram
    // **********
    // no reset: contents are undefined after power-up
    always_ff @(posedge mclk)
    begin
        if (wr_en && eff_gpr)
        begin
            gpr_mem[eff_addr[dmsr_pkg::GPR_IDX_W-1:0]] <= wr_data; // RULE2 RULE19
        end
    end

    // **********
    // indirect pointer
    // **********
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            indirect_pointer_r <= dmsr_pkg::RESET_BYTE;
        end
        else if (wr_en && eff_ok && (eff_addr == dmsr_pkg::ADDR_INDIRECT_PTR))
        begin
            indirect_pointer_r <= wr_data; // RULE6
        end
    end

    // **********
    // accumulator
    // **********
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            acc_r <= dmsr_pkg::RESET_BYTE;
        end
        else if (acc_load)
        begin
            acc_r <= alu_bus.result; // RULE7
        end
        else if (wr_en && eff_ok && (eff_addr == dmsr_pkg::ADDR_ACC))
        begin
            acc_r <= wr_data;
        end
    end

    // **********
    // program counter low byte
    // **********
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            pc_jump_r <= 1'b0;
            pc_jump_low_r <= dmsr_pkg::RESET_BYTE;
        end
        else
        begin
            pc_jump_r <= wr_en && eff_ok && (eff_addr == dmsr_pkg::ADDR_PCL); // RULE8
            if (wr_en && eff_ok && (eff_addr == dmsr_pkg::ADDR_PCL))
            begin
                pc_jump_low_r <= wr_data; // RULE8
            end
        end
    end

    // **********
    // table pointer and high latch
    // **********
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            tbl_ptr_r <= dmsr_pkg::RESET_BYTE;
        end
        else if (wr_en && eff_ok && (eff_addr == dmsr_pkg::ADDR_TBL_PTR))
        begin
            tbl_ptr_r <= wr_data; // RULE9
        end
    end

    // read-only to the program; only the table fetch loads it
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            tbl_high_r <= dmsr_pkg::RESET_BYTE;
        end
        else if (tbl_read)
        begin
            tbl_high_r <= tbl_high_in; // RULE9
        end
    end

    // **********
    // arithmetic flags
    // **********
    // a direct write of the flag byte wins over the alu's own update;
    // nothing here stacks the flags, so handlers must save them
    always_ff @(posedge mclk) // RULE18
    begin
        if (!resetn)
        begin
            carry_r <= 1'b0;
            nibble_half_flag_r <= 1'b0;
            zero_r <= 1'b0;
            twos_complement_flag_r <= 1'b0;
        end
        else if (wr_en && eff_ok && (eff_addr == dmsr_pkg::ADDR_FLAGS))
        begin
            carry_r <= wr_data[dmsr_pkg::FLAG_C]; // RULE11
            nibble_half_flag_r <= wr_data[dmsr_pkg::FLAG_AC]; // RULE11
            zero_r <= wr_data[dmsr_pkg::FLAG_Z]; // RULE11
            twos_complement_flag_r <= wr_data[dmsr_pkg::FLAG_OV]; // RULE11
        end
        else if (go && is_alu)
        begin
            if (alu_bus.upd_c)
            begin
                carry_r <= alu_bus.c; // RULE14
            end
            if (alu_bus.upd_ac)
            begin
                nibble_half_flag_r <= alu_bus.ac; // RULE15
            end
            if (alu_bus.upd_z)
            begin
                zero_r <= alu_bus.z; // RULE16
            end
            if (alu_bus.upd_ov)
            begin
                twos_complement_flag_r <= alu_bus.ov; // RULE17
            end
        end
    end

    // **********
    // system flags
    // **********
    // set beats clear so a timeout coinciding with a clear is kept
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            watchdog_expired_flag_r <= 1'b0; // RULE12
        end
        else if (wdt_timeout)
        begin
            watchdog_expired_flag_r <= 1'b1; // RULE12
        end
        else if (watchdog_clear_instruction || stop_instruction)
        begin
            watchdog_expired_flag_r <= 1'b0; // RULE12
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            power_down_flag_r <= 1'b0; // RULE13
        end
        else if (stop_instruction)
        begin
            power_down_flag_r <= 1'b1; // RULE13
        end
        else if (watchdog_clear_instruction)
        begin
            power_down_flag_r <= 1'b0; // RULE13
        end
    end

    always_comb
    begin
        flags_nxt = 8'h00; // RULE10
        flags_nxt[dmsr_pkg::FLAG_C] = carry_r;
        flags_nxt[dmsr_pkg::FLAG_AC] = nibble_half_flag_r;
        flags_nxt[dmsr_pkg::FLAG_Z] = zero_r;
        flags_nxt[dmsr_pkg::FLAG_OV] = twos_complement_flag_r;
        flags_nxt[dmsr_pkg::FLAG_PDF] = power_down_flag_r;
        flags_nxt[dmsr_pkg::FLAG_TO] = watchdog_expired_flag_r;
    end

    // **********
    // read return
    // **********
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            rd_data_r <= dmsr_pkg::RESET_BYTE;
        end
        else if (go)
        begin
            rd_data_r <= mem_val;
        end
    end

    assign rd_data = rd_data_r;
    assign pc_jump = pc_jump_r;
    assign pc_jump_low = pc_jump_low_r;
    assign tbl_ptr = tbl_ptr_r;
    assign table_high_latch = tbl_high_r;
    assign acc = acc_r;
    assign flags = flags_nxt;
endmodule

// File: testbench/dmsr_core_model.sv
`timescale 1ns/1ps

module dmsr_core_model #(
    parameter logic [7:0] PC_LOW = 8'h5A,
    parameter logic [7:0] TBL_XOR = 8'hA5
)
(
    // table fetch
    input wire logic mclk,
    input wire logic [7:0] tbl_ptr,
    output logic [7:0] tbl_high_in,
    // program counter
    output logic [7:0] pc_low_in
);
    // fetch lags the pointer a cycle, as a program memory read would
    always_ff @(posedge mclk)
    begin
        tbl_high_in <= tbl_ptr ^ TBL_XOR;
    end
    assign pc_low_in = PC_LOW;
endmodule

// File: testbench/dmsr_top_checker.sv
`timescale 1ns/1ps

module dmsr_top_checker #(
    parameter int GPR_WORDS = 32
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // command and events
    input wire logic cmd_valid,
    input wire dmsr_pkg::dmsr_op_t cmd_op,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_imm,
    input wire logic cmd_use_imm,
    input wire logic cmd_to_mem,
    input wire logic tbl_read,
    input wire logic [7:0] tbl_high_in,
    input wire logic wdt_timeout,
    input wire logic watchdog_clear_instruction,
    input wire logic stop_instruction,
    // observed state
    input wire logic cmd_ready,
    input wire logic pc_jump,
    input wire logic [7:0] pc_jump_low,
    input wire logic [7:0] table_high_latch,
    input wire logic [7:0] acc,
    input wire logic [7:0] flags
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    wire logic take = cmd_valid && cmd_ready;
    wire logic quiet = !wdt_timeout && !stop_instruction && !watchdog_clear_instruction;

    sequence s_pcl_write;
        take && cmd_op == dmsr_pkg::OP_STORE && cmd_addr == 8'h06;
    endsequence
    sequence s_dummy;
        pc_jump && !cmd_ready ##1 cmd_ready && !pc_jump;
    endsequence
    sequence s_add_imm;
        take && cmd_op == dmsr_pkg::OP_ADD && cmd_use_imm && !cmd_to_mem;
    endsequence

    chk_pcl_dummy: assert property (s_pcl_write |=> s_dummy)
        else $error("jump dummy cycle wrong");
    chk_jump_target: assert property (s_pcl_write |=> pc_jump_low == $past(acc))
        else $error("jump target wrong");
    chk_ready_short: assert property (!cmd_ready |=> cmd_ready)
        else $error("ready low too long");
    chk_add_acc: assert property (s_add_imm |=> {flags[0], acc} == 9'($past(acc)) + 9'($past(cmd_imm)))
        else $error("add result wrong");
    chk_top_zero: assert property (flags[7:6] == 2'h0)
        else $error("flag top bits set");
    chk_tbl_load: assert property (tbl_read |=> table_high_latch == $past(tbl_high_in))
        else $error("table latch not loaded");
    chk_to_set: assert property (wdt_timeout |=> flags[5])
        else $error("timeout flag not set");
    chk_stop_pdf: assert property (stop_instruction && !wdt_timeout |=> flags[5:4] == 2'h1)
        else $error("stop flags wrong");
    chk_clr_both: assert property (watchdog_clear_instruction && !stop_instruction && !wdt_timeout |=> flags[5:4] == 2'h0)
        else $error("watchdog clear flags wrong");
    chk_sys_hold: assert property (quiet |=> $stable(flags[5:4]))
        else $error("system flags changed");
endmodule

bind dmsr_top dmsr_top_checker #(.GPR_WORDS(GPR_WORDS)) u_chk (.mclk(mclk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_imm(cmd_imm),
    .cmd_use_imm(cmd_use_imm), .cmd_to_mem(cmd_to_mem), .tbl_read(tbl_read),
    .tbl_high_in(tbl_high_in), .wdt_timeout(wdt_timeout), .stop_instruction(stop_instruction),
    .watchdog_clear_instruction(watchdog_clear_instruction), .cmd_ready(cmd_ready),
    .pc_jump(pc_jump), .pc_jump_low(pc_jump_low), .table_high_latch(table_high_latch),
    .acc(acc), .flags(flags));

// File: testbench/testbench.sv
`timescale 1ns/1ps

module testbench;
    localparam logic [7:0] PCLO = 8'h5A;
    localparam logic [7:0] TX = 8'hA5;
    logic mclk, resetn, cmd_valid, cmd_use_imm, cmd_to_mem, cmd_ready, pc_jump, tbl_read;
    logic wdt_timeout, watchdog_clear_instruction, stop_instruction;
    logic [2:0] cmd_bit;
    logic [7:0] cmd_addr, cmd_imm, rd_data, pc_low_in, pc_jump_low, tbl_high_in, tbl_ptr;
    logic [7:0] table_high_latch, acc, flags;
    dmsr_pkg::dmsr_op_t cmd_op;
    int errors, n_compared;

    dmsr_top uut (.mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_imm(cmd_imm), .cmd_use_imm(cmd_use_imm),
        .cmd_to_mem(cmd_to_mem), .cmd_bit(cmd_bit), .cmd_ready(cmd_ready), .rd_data(rd_data),
        .pc_low_in(pc_low_in), .pc_jump(pc_jump), .pc_jump_low(pc_jump_low),
        .tbl_read(tbl_read), .tbl_high_in(tbl_high_in), .tbl_ptr(tbl_ptr),
        .table_high_latch(table_high_latch), .wdt_timeout(wdt_timeout),
        .watchdog_clear_instruction(watchdog_clear_instruction),
        .stop_instruction(stop_instruction), .acc(acc), .flags(flags));
    dmsr_core_model #(.PC_LOW(PCLO), .TBL_XOR(TX)) u_core (.mclk(mclk), .tbl_ptr(tbl_ptr),
        .tbl_high_in(tbl_high_in), .pc_low_in(pc_low_in));

    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    // **********
    // shared tasks
    // **********
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic set(input dmsr_pkg::dmsr_op_t op, input logic [7:0] ad, im,
        input logic ui, tm, input logic [2:0] bt);
        cmd_valid <= 1'h1;
        cmd_op <= op;
        cmd_addr <= ad;
        cmd_imm <= im;
        cmd_use_imm <= ui;
        cmd_to_mem <= tm;
        cmd_bit <= bt;
    endtask

    // holds the command until an edge sees ready high
    task automatic cmd(input dmsr_pkg::dmsr_op_t op, input logic [7:0] ad, im = 8'h00,
        input logic ui = 1'h0, tm = 1'h0, input logic [2:0] bt = 3'h0);
        logic ok;
        ok = 1'h0;
        @(posedge mclk);
        set(op, ad, im, ui, tm, bt);
        for (int k = 0; k < 8 && !ok; k++)
        begin
            @(negedge mclk);
            ok = (cmd_ready === 1'h1);
            @(posedge mclk);
        end
        cmd_valid <= 1'h0;
        if (!ok)
        begin
            errors++;
            complete_run();
        end
        @(negedge mclk);
    endtask

    task automatic wr(input logic [7:0] ad, v);
        cmd(dmsr_pkg::OP_MOV, 8'h00, v, 1'h1);
        cmd(dmsr_pkg::OP_STORE, ad);
    endtask

    task automatic rd(input logic [7:0] ad, exp);
        cmd(dmsr_pkg::OP_MOV, ad);
        check(acc, exp);
        check(rd_data, exp);
    endtask

    task automatic alu(input dmsr_pkg::dmsr_op_t op, input logic [7:0] im, ea, ef);
        cmd(op, 8'h00, im, 1'h1);
        check(acc, ea);
        check(flags, ef);
    endtask

    task automatic ev(input logic [3:0] w);
        @(posedge mclk);
        {tbl_read, wdt_timeout, stop_instruction, watchdog_clear_instruction} <= w;
        @(posedge mclk);
        {tbl_read, wdt_timeout, stop_instruction, watchdog_clear_instruction} <= 4'h0;
        @(negedge mclk);
    endtask

    // expected {OV,Z,AC,C} and result of an add or subtract
    function automatic logic [11:0] arith(input logic [7:0] a, b, input logic sub);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] m;
        bb = sub ? ~b : b;
        s = {1'h0, a} + {1'h0, bb} + 9'(sub);
        n = {1'h0, a[3:0]} + {1'h0, bb[3:0]} + 5'(sub);
        m = {1'h0, a[6:0]} + {1'h0, bb[6:0]} + 8'(sub);
        return {s[8] ^ m[7], s[7:0] == 8'h00, n[4], s[8], s[7:0]};
    endfunction

    // **********
    // scenarios
    // **********
    task automatic t_ram;
        wr(8'h20, 8'h3C);
        wr(8'h3F, 8'hC3);
        rd(8'h20, 8'h3C);
        rd(8'h3F, 8'hC3);
        wr(8'h01, 8'h22);
        wr(8'h00, 8'h96);
        rd(8'h22, 8'h96);
        cmd(dmsr_pkg::OP_SETB, 8'h00, 8'h00, 1'h0, 1'h0, 3'h0);
        cmd(dmsr_pkg::OP_CLRB, 8'h22, 8'h00, 1'h0, 1'h0, 3'h7);
        rd(8'h00, 8'h17);
        cmd(dmsr_pkg::OP_INC, 8'h01, 8'h00, 1'h0, 1'h1);
        rd(8'h01, 8'h23);
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h55);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h00);
    endtask

    task automatic t_unused;
        logic [7:0] ua [4];
        ua = '{8'h02, 8'h09, 8'h18, 8'h1F};
        foreach (ua[i])
        begin
            wr(ua[i], 8'hFF);
            rd(ua[i], 8'h00);
        end
    endtask

    task automatic t_flags;
        wr(8'h0A, 8'hFF);
        check(flags, 8'h0F);
        ev(4'h4);
        check(flags, 8'h2F);
        wr(8'h0A, 8'h00);
        check(flags, 8'h20);
        ev(4'h2);
        check(flags, 8'h10);
        ev(4'h1);
        check(flags, 8'h00);
    endtask

    task automatic t_alu;
        logic [16:0] tv [4];
        logic [11:0] e;
        tv = '{{1'h0, 16'h7F01}, {1'h1, 16'h0305}, {1'h0, 16'hFF01}, {1'h1, 16'h0505}};
        foreach (tv[i])
        begin
            cmd(dmsr_pkg::OP_MOV, 8'h00, tv[i][15:8], 1'h1);
            cmd(tv[i][16] ? dmsr_pkg::OP_SUB : dmsr_pkg::OP_ADD, 8'h00, tv[i][7:0], 1'h1);
            e = arith(tv[i][15:8], tv[i][7:0], tv[i][16]);
            check(acc, e[7:0]);
            check(flags, {4'h0, e[11:8]});
        end
        cmd(dmsr_pkg::OP_MOV, 8'h00, 8'hF0, 1'h1);
        alu(dmsr_pkg::OP_AND, 8'h0F, 8'h00, 8'h07);
        alu(dmsr_pkg::OP_RLC, 8'h00, 8'h01, 8'h06);
        alu(dmsr_pkg::OP_RRC, 8'h01, 8'h00, 8'h07);
        alu(dmsr_pkg::OP_ADC, 8'h0F, 8'h10, 8'h02);
        alu(dmsr_pkg::OP_SBC, 8'h10, 8'hFF, 8'h00);
        alu(dmsr_pkg::OP_XOR, 8'hFF, 8'h00, 8'h04);
        alu(dmsr_pkg::OP_OR, 8'h30, 8'h30, 8'h00);
        alu(dmsr_pkg::OP_DEC, 8'h01, 8'h00, 8'h04);
    endtask

    task automatic t_tbl;
        wr(8'h07, 8'h10);
        check(tbl_ptr, 8'h10);
        ev(4'h8);
        check(table_high_latch, 8'h10 ^ TX);
        wr(8'h08, 8'h00);
        rd(8'h08, 8'h10 ^ TX);
        cmd(dmsr_pkg::OP_INC, 8'h07, 8'h00, 1'h0, 1'h1);
        check(tbl_ptr, 8'h11);
    endtask

    // a command queued behind the jump must be dropped once, then taken
    task automatic t_pcl;
        rd(8'h06, PCLO);
        cmd(dmsr_pkg::OP_MOV, 8'h00, 8'h44, 1'h1);
        @(posedge mclk);
        set(dmsr_pkg::OP_STORE, 8'h06, 8'h00, 1'h0, 1'h0, 3'h0);
        @(posedge mclk);
        set(dmsr_pkg::OP_ADD, 8'h00, 8'h05, 1'h1, 1'h0, 3'h0);
        @(negedge mclk);
        check({7'h00, pc_jump}, 8'h01);
        check(pc_jump_low, 8'h44);
        check({7'h00, cmd_ready}, 8'h00);
        @(posedge mclk);
        @(posedge mclk);
        cmd_valid <= 1'h0;
        @(negedge mclk);
        check(acc, 8'h49);
    endtask

    initial
    begin
        errors = 0;
        n_compared = 0;
        resetn = 1'h0;
        {cmd_valid, cmd_use_imm, cmd_to_mem, tbl_read} = 4'h0;
        {wdt_timeout, stop_instruction, watchdog_clear_instruction} = 3'h0;
        cmd_op = dmsr_pkg::OP_NOP;
        {cmd_addr, cmd_imm, cmd_bit} = 19'h00000;
        repeat (4) @(posedge mclk);
        resetn <= 1'h1;
        @(negedge mclk);
        check(flags, 8'h00);
        check({7'h00, cmd_ready}, 8'h01);
        t_ram();
        t_unused();
        t_flags();
        t_alu();
        t_tbl();
        t_pcl();
        complete_run();
    end
endmodule
